// [logic/lamp_params.svh]
// Constants for the drive status lamp encoder
//
// Summary of operation
// - Sealed, EtherNet/IP: status lamp dark, flashing when ready, steady with I/O link.
// - Sealed, SERCOS III: status lamp dark, flashing while starting, steady at phase four.
// - CANopen: fieldbus fault lamp dark when node ready, red when node defective.
// - EtherCAT: fieldbus fault lamp dark when bus ready, red when bus defective.
// - PROFINET: fault lamp dark when talking, red without link, flashing without I/O.
// - EtherNet/IP: fault lamp dark when talking, flashing red after connection timeout.
// - SERCOS III: fault lamp dark when ready, red on error or before connection.
// - Cabinet: lamps are drive status, drive fault, fieldbus status, fieldbus fault.
// - Cabinet drive status: dark unpowered or defective, flashing stage off, steady on.
// - Cabinet drive fault: dark when functional, flashing red defective with stage off.
// - Cabinet CANopen status: dark unpowered, flashing pre-operational, steady operational.
// - Cabinet EtherCAT status: dark, slow, single flash, steady, rapid by state.
// - Cabinet PROFINET status: dark until interface ready, then steady green.
// - Cabinet EtherNet/IP status: dark, flashing when ready, steady with I/O link.
// - Cabinet SERCOS III status: dark, flashing, single flash safe-op, steady phase four.
`ifndef LAMP_PARAMS_SVH
`define LAMP_PARAMS_SVH

// ==================================================================
// Register map (byte addresses, low address bits decoded)
`define REG_CONFIG 8'h00
`define REG_SLOW_HALF 8'h04
`define REG_FAST_HALF 8'h08
`define REG_LAMPS 8'h0C
`define REG_INPUTS 8'h10
`define ADDR_W 8

// ==================================================================
// Field positions and reset values
`define CFG_CABINET_BIT 0
`define CFG_PROTO_LSB 1
`define CFG_PROTO_MSB 3
`define CFG_RESET 4'h0
`define DIV_W 25
`define HSIZE_WORD 3'h2

// ==================================================================
// Timing
`define CLK_PERIOD_NS 10
`define SLOW_HALF_MS 200
`define FAST_HALF_MS 50
`define SLOW_HALF_CYC (`SLOW_HALF_MS * 1000000 / `CLK_PERIOD_NS)
`define FAST_HALF_CYC (`FAST_HALF_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// [logic/lamp_pkg.sv]
// Types shared by the drive status lamp encoder
`default_nettype none
package lamp_pkg;
  typedef enum logic [2:0] {PROTO_CAN, PROTO_ECAT, PROTO_PN, PROTO_EIP, PROTO_SERCOS} proto_t;
  typedef enum logic [2:0] {LS_OFF, LS_PREOP, LS_SAFEOP, LS_OP, LS_BOOT, LS_STOPPED} link_state_t;
  typedef enum logic [2:0] {PAT_DARK, PAT_STEADY, PAT_SLOW, PAT_FAST, PAT_SINGLE} pat_t;
  typedef struct packed {
    logic powered;
    logic functional;
    logic stage_en;
  } drive_cond_t;
  typedef struct packed {
    link_state_t state;
    logic fault;
    logic conn;
    logic io_active;
    logic timeout;
  } bus_cond_t;
  typedef struct packed {
    logic green;
    logic red;
  } lamp_t;
  typedef struct packed {
    lamp_t lamp_one;
    lamp_t lamp_two;
    lamp_t lamp_three;
    lamp_t lamp_four;
  } lamps_t;
  typedef struct packed {
    proto_t proto;
    logic cabinet;
  } cfg_t;
endpackage
`default_nettype wire

// [logic/drive_status_lamp_encoder.sv]
// Drive and fieldbus condition to indicator lamp encoder with AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "lamp_params.svh"

module drive_status_lamp_encoder #(
  parameter logic [`DIV_W-1:0] SLOW_HALF_CYCLES = `DIV_W'(`SLOW_HALF_CYC),
  parameter logic [`DIV_W-1:0] FAST_HALF_CYCLES = `DIV_W'(`FAST_HALF_CYC)
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire lamp_pkg::drive_cond_t drive_in, // Drive controller condition
  input wire lamp_pkg::bus_cond_t bus_in, // Fieldbus stack condition
  output lamp_pkg::lamps_t lamps // Lamp drive, one bit per colour
);
  import lamp_pkg::*;

  // ==================================================================
  // Bus slave
  logic addr_take;
  logic dp_wr;
  logic rd_wait;
  logic [`ADDR_W-1:0] dp_addr;
  cfg_t cfg;
  logic [`DIV_W-1:0] slow_half;
  logic [`DIV_W-1:0] fast_half;
  logic wr_go;

  assign addr_take = hsel && htrans[1] && hready;
  assign wr_go = dp_wr && hready;
  // Reads take one wait state so read data comes from a flip-flop
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= '0;
    end else begin
      if (addr_take) begin
        dp_wr <= hwrite && (hsize == `HSIZE_WORD);
        rd_wait <= !hwrite;
        dp_addr <= haddr[`ADDR_W-1:0];
      end else begin
        rd_wait <= 1'b0;
        if (hready) begin
          dp_wr <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= cfg_t'(`CFG_RESET);
    end else if (wr_go && dp_addr == `REG_CONFIG) begin
      cfg.cabinet <= hwdata[`CFG_CABINET_BIT];
      cfg.proto <= proto_t'(hwdata[`CFG_PROTO_MSB:`CFG_PROTO_LSB]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_half <= SLOW_HALF_CYCLES;
      fast_half <= FAST_HALF_CYCLES;
    end else if (wr_go) begin
      if (dp_addr == `REG_SLOW_HALF) begin
        slow_half <= hwdata[`DIV_W-1:0];
      end
      if (dp_addr == `REG_FAST_HALF) begin
        fast_half <= hwdata[`DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_wait) begin
      unique case (dp_addr)
        `REG_CONFIG: hrdata <= {28'h0000000, cfg.proto, cfg.cabinet};
        `REG_SLOW_HALF: hrdata <= {7'h00, slow_half};
        `REG_FAST_HALF: hrdata <= {7'h00, fast_half};
        `REG_LAMPS: hrdata <= {24'h000000, lamps};
        `REG_INPUTS: hrdata <= {22'h000000, drive_in, bus_in};
        default: hrdata <= '0;
      endcase
    end
  end

  // ==================================================================
  // Flash pattern dividers
  logic [`DIV_W-1:0] slow_cnt;
  logic [`DIV_W-1:0] fast_cnt;
  logic [1:0] slow_ph;
  logic fast_ph;
  logic slow_tick;
  logic fast_tick;

  // Compare with >= so a shortened period never strands the counter
  assign slow_tick = ({1'b0, slow_cnt} + 1'b1) >= {1'b0, slow_half};
  assign fast_tick = ({1'b0, fast_cnt} + 1'b1) >= {1'b0, fast_half};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt <= '0;
      slow_ph <= 2'h0;
    end else if (slow_tick) begin
      slow_cnt <= '0;
      slow_ph <= slow_ph + 2'h1;
    end else begin
      slow_cnt <= slow_cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_cnt <= '0;
      fast_ph <= 1'b0;
    end else if (fast_tick) begin
      fast_cnt <= '0;
      fast_ph <= !fast_ph;
    end else begin
      fast_cnt <= fast_cnt + 1'b1;
    end
  end

  // Single flash: lit for one slow half period out of four
  function automatic logic lit(input pat_t p, input logic [1:0] sph, input logic fph);
    unique case (p)
      PAT_DARK: lit = 1'b0;
      PAT_STEADY: lit = 1'b1;
      PAT_SLOW: lit = !sph[0];
      PAT_FAST: lit = !fph;
      PAT_SINGLE: lit = (sph == 2'h0);
      default: lit = 1'b0;
    endcase
  endfunction

  // ==================================================================
  // Pattern selection
  pat_t drv_pat;
  pat_t dflt_pat;
  pat_t st_pat;
  pat_t flt_pat;
  lamps_t next_lamps;

  always_comb begin
    if (!drive_in.powered || !drive_in.functional) begin
      drv_pat = PAT_DARK;
    end else if (drive_in.stage_en) begin
      drv_pat = PAT_STEADY;
    end else begin
      drv_pat = PAT_SLOW;
    end
    // A defective drive with its stage still enabled has no pattern; kept dark
    if (drive_in.powered && !drive_in.functional && !drive_in.stage_en) begin
      dflt_pat = PAT_SLOW;
    end else begin
      dflt_pat = PAT_DARK;
    end
  end

  always_comb begin
    st_pat = PAT_DARK;
    flt_pat = PAT_DARK;
    unique case (cfg.proto)
      PROTO_CAN: begin
        unique case (bus_in.state)
          LS_PREOP, LS_STOPPED: st_pat = PAT_SLOW;
          LS_OP: st_pat = PAT_STEADY;
          default: st_pat = PAT_DARK;
        endcase
        flt_pat = bus_in.fault ? PAT_STEADY : PAT_DARK;
      end
      PROTO_ECAT: begin
        unique case (bus_in.state)
          LS_PREOP: st_pat = PAT_SLOW;
          LS_SAFEOP: st_pat = PAT_SINGLE;
          LS_OP: st_pat = PAT_STEADY;
          LS_BOOT: st_pat = PAT_FAST;
          default: st_pat = PAT_DARK;
        endcase
        flt_pat = bus_in.fault ? PAT_STEADY : PAT_DARK;
      end
      PROTO_PN: begin
        st_pat = (bus_in.state == LS_OFF) ? PAT_DARK : PAT_STEADY;
        if (bus_in.io_active) begin
          flt_pat = PAT_DARK;
        end else if (bus_in.conn) begin
          flt_pat = PAT_SLOW;
        end else begin
          flt_pat = PAT_STEADY;
        end
      end
      PROTO_EIP: begin
        unique case (bus_in.state)
          LS_OP: st_pat = PAT_STEADY;
          LS_OFF: st_pat = PAT_DARK;
          default: st_pat = PAT_SLOW;
        endcase
        flt_pat = bus_in.timeout ? PAT_SLOW : PAT_DARK;
      end
      PROTO_SERCOS: begin
        unique case (bus_in.state)
          LS_OFF: st_pat = PAT_DARK;
          LS_OP: st_pat = PAT_STEADY;
          LS_SAFEOP: st_pat = cfg.cabinet ? PAT_SINGLE : PAT_SLOW;
          default: st_pat = PAT_SLOW;
        endcase
        flt_pat = (bus_in.fault || bus_in.state != LS_OP) ? PAT_STEADY : PAT_DARK;
      end
      default: begin
        st_pat = PAT_DARK;
        flt_pat = PAT_DARK;
      end
    endcase
  end

  // ==================================================================
  // Lamp assignment per housing
  always_comb begin
    next_lamps = '0;
    if (cfg.cabinet) begin
      next_lamps.lamp_one.green = lit(drv_pat, slow_ph, fast_ph);
      next_lamps.lamp_two.red = lit(dflt_pat, slow_ph, fast_ph);
      next_lamps.lamp_three.green = lit(st_pat, slow_ph, fast_ph);
      next_lamps.lamp_four.red = lit(flt_pat, slow_ph, fast_ph);
    end else begin
      // The sealed housing's drive lamp is handled elsewhere
      next_lamps.lamp_two.green = lit(st_pat, slow_ph, fast_ph);
      next_lamps.lamp_three.red = lit(flt_pat, slow_ph, fast_ph);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamps <= '0;
    end else begin
      lamps <= next_lamps;
    end
  end

  // ==================================================================
  // Checks
  logic fbs;
  logic fbf;

  assign fbs = cfg.cabinet ? lamps.lamp_three.green : lamps.lamp_two.green;
  assign fbf = cfg.cabinet ? lamps.lamp_four.red : lamps.lamp_three.red;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence rd_addr;
    addr_take && !hwrite;
  endsequence

  sequence rd_answer;
    !hreadyout ##1 (hreadyout && !rd_wait);
  endsequence

  sequence ecat_boot;
    cfg.proto == PROTO_ECAT && cfg.cabinet && bus_in.state == LS_BOOT;
  endsequence

  sequence ecat_safeop;
    cfg.proto == PROTO_ECAT && cfg.cabinet && bus_in.state == LS_SAFEOP;
  endsequence

  sequence drv_defect;
    cfg.cabinet && drive_in.powered && !drive_in.functional && !drive_in.stage_en;
  endsequence

  a_read_wait_state: assert property (rd_addr |=> rd_answer)
    else $error("read answer not after one wait state");

  a_eip_sealed_steady: assert property (
    (cfg.proto == PROTO_EIP && !cfg.cabinet && bus_in.state == LS_OP) ##1 !$changed(cfg)
      |-> lamps.lamp_two.green)
    else $error("sealed EtherNet/IP status not steady with I/O link");

  a_sercos_sealed_dark: assert property (
    (cfg.proto == PROTO_SERCOS && !cfg.cabinet && bus_in.state == LS_OFF) ##1 !$changed(cfg)
      |-> !lamps.lamp_two.green && lamps.lamp_three.red)
    else $error("sealed SERCOS lamps wrong without communication");

  a_can_fault_red: assert property (
    (cfg.proto == PROTO_CAN && bus_in.fault) ##1 !$changed(cfg) |-> fbf)
    else $error("CANopen fault lamp not red for defective node");

  a_ecat_fault_dark: assert property (
    (cfg.proto == PROTO_ECAT && !bus_in.fault) ##1 !$changed(cfg) |-> !fbf)
    else $error("EtherCAT fault lamp lit on ready bus");

  a_pn_no_link: assert property (
    (cfg.proto == PROTO_PN && !bus_in.conn && !bus_in.io_active) ##1 !$changed(cfg) |-> fbf)
    else $error("PROFINET fault lamp not red without link");

  a_eip_fault_dark: assert property (
    (cfg.proto == PROTO_EIP && !bus_in.timeout) ##1 !$changed(cfg) |-> !fbf)
    else $error("EtherNet/IP fault lamp lit without timeout");

  a_sercos_not_up: assert property (
    (cfg.proto == PROTO_SERCOS && bus_in.state != LS_OP) ##1 !$changed(cfg) |-> fbf)
    else $error("SERCOS fault lamp dark before connection");

  a_drive_running: assert property (
    (cfg.cabinet && drive_in.powered && drive_in.functional && drive_in.stage_en)
      ##1 cfg.cabinet |-> lamps.lamp_one.green && !lamps.lamp_two.red)
    else $error("drive lamps wrong for running drive");

  a_drive_fault_flash: assert property (
    drv_defect |=> lamps.lamp_two.red == ($past(slow_ph) inside {2'h0, 2'h2}))
    else $error("drive fault lamp not flashing for defective drive");

  a_pn_status_steady: assert property (
    (cfg.cabinet && cfg.proto == PROTO_PN && bus_in.state != LS_OFF)
      ##1 !$changed(cfg) |-> fbs)
    else $error("PROFINET status lamp not steady on ready interface");

  a_ecat_rapid: assert property (
    ecat_boot ##1 ecat_boot |-> lamps.lamp_three.green == !$past(fast_ph))
    else $error("bootstrap lamp not following the rapid divider");

  a_ecat_single: assert property (
    ecat_safeop ##1 ecat_safeop |-> lamps.lamp_three.green == ($past(slow_ph) == 2'h0))
    else $error("safe-operational lamp not giving single flash");

  a_slow_phase_step: assert property (
    slow_tick |=> slow_ph == $past(slow_ph) + 2'h1 && slow_cnt == '0)
    else $error("slow divider did not advance on its tick");

endmodule
`default_nettype wire

// [testbench/cond_source.sv]
// Behavioural drive controller and fieldbus stack feeding the lamp encoder
`timescale 1ns/10ps
`default_nettype none

module cond_source (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, active low
  input wire lamp_pkg::drive_cond_t want_drive, // Drive condition the bench commands
  input wire lamp_pkg::bus_cond_t want_bus, // Stack condition the bench commands
  output lamp_pkg::drive_cond_t drive_in, // Drive condition to the encoder
  output lamp_pkg::bus_cond_t bus_in // Fieldbus condition to the encoder
);
  import lamp_pkg::*;

  // ==================================================================
  // Conditions
  // Registered so that every change lands just after a clock edge, as real logic does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_in <= '0;
      bus_in <= '0;
    end else begin
      drive_in <= want_drive;
      bus_in <= want_bus;
    end
  end
endmodule

`default_nettype wire

// [testbench/drive_status_lamp_encoder_tb.sv]
// Self-checking bench for the drive status lamp encoder
`timescale 1ns/10ps
`default_nettype none
`include "lamp_params.svh"

module drive_status_lamp_encoder_tb;
  import lamp_pkg::*;

  // ==================================================================
  // Signals
  localparam int DK = 0, ST = 1, SL = 2, FS = 3, SG = 4, NA = 7;
  // Short dividers: 96 cycles hold whole periods of every pattern
  localparam int LIT_E[5] = '{0, 96, 48, 48, 24};
  localparam int RISE_E[5] = '{0, 0, 6, 16, 3};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  drive_cond_t want_drive, drive_in;
  bus_cond_t want_bus, bus_in;
  lamps_t lamps;
  int err_total, checks;

  drive_status_lamp_encoder #(.SLOW_HALF_CYCLES(25'h8), .FAST_HALF_CYCLES(25'h3)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drive_in(drive_in),
    .bus_in(bus_in), .lamps(lamps));

  cond_source src (.hclk(hclk), .hresetn(hresetn), .want_drive(want_drive),
    .want_bus(want_bus), .drive_in(drive_in), .bus_in(bus_in));

  // ==================================================================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("mismatch hreadyout expected 1 seen %b", hreadyout);
      end_of_test();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, `HSIZE_WORD, d);
    chk(what, exp, d);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Sets housing, protocol and conditions, then counts lit cycles and rises per lamp
  task automatic row(input logic [3:0] cfg, input logic [2:0] drv, input logic [6:0] bus,
                     input int p0, input int p1, input int p2, input int p3);
    int lit[4], rise[4], bits[4], p[4];
    logic [7:0] prev;
    logic [31:0] d;
    p = '{p0, p1, p2, p3};
    lit = '{default: 0};
    rise = '{default: 0};
    if (cfg[0]) begin
      bits = '{7, 4, 3, 0};
    end else begin
      bits = '{7, 5, 2, 0};
    end
    ahb(1'b1, `REG_CONFIG, {28'h0, cfg}, `HSIZE_WORD, d);
    want_drive <= drv;
    want_bus <= bus;
    repeat (4) @(posedge hclk);
    rd_chk("inputs", `REG_INPUTS, {22'h0, drv, bus});
    #1;
    prev = lamps;
    for (int c = 0; c < 96; c++) begin
      @(posedge hclk);
      #1;
      for (int k = 0; k < 4; k++) begin
        lit[k] += int'(lamps[bits[k]] === 1'b1);
        rise[k] += int'(lamps[bits[k]] === 1'b1 && prev[bits[k]] !== 1'b1);
      end
      prev = lamps;
    end
    for (int k = 0; k < 4; k++) begin
      if (p[k] != NA) begin
        chk($sformatf("lamp bit %0d lit cycles", bits[k]), LIT_E[p[k]], lit[k]);
        chk($sformatf("lamp bit %0d rises", bits[k]), RISE_E[p[k]], rise[k]);
      end
    end
    // Realign so the next request is driven at a rising edge
    @(posedge hclk);
  endtask

  // ==================================================================
  // Clock, reset and sequence
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    logic [31:0] d;
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    want_drive = '0;
    want_bus = '0;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("config reset", `REG_CONFIG, 32'h0);
    rd_chk("slow half", `REG_SLOW_HALF, 32'h8);
    rd_chk("fast half", `REG_FAST_HALF, 32'h3);
    rd_chk("unmapped", 8'h14, 32'h0);
    ahb(1'b1, `REG_CONFIG, 32'h9, 3'h0, d);
    rd_chk("config after byte write", `REG_CONFIG, 32'h0);
    // Sealed housing: unused, fieldbus status, fieldbus fault, unused
    row(4'h6, 3'b111, {3'd0, 4'b0000}, DK, DK, DK, DK);
    row(4'h6, 3'b111, {3'd1, 4'b0101}, DK, SL, SL, DK);
    row(4'h6, 3'b111, {3'd3, 4'b0110}, DK, ST, DK, DK);
    row(4'h8, 3'b111, {3'd0, 4'b0000}, DK, DK, ST, DK);
    row(4'h8, 3'b111, {3'd2, 4'b0100}, DK, SL, ST, DK);
    row(4'h8, 3'b111, {3'd3, 4'b0100}, DK, ST, DK, DK);
    row(4'h8, 3'b111, {3'd3, 4'b1100}, DK, ST, ST, DK);
    row(4'h0, 3'b111, {3'd3, 4'b1000}, DK, NA, ST, DK);
    row(4'h0, 3'b111, {3'd3, 4'b0000}, DK, NA, DK, DK);
    row(4'h2, 3'b111, {3'd3, 4'b1000}, DK, NA, ST, DK);
    row(4'h2, 3'b111, {3'd3, 4'b0000}, DK, NA, DK, DK);
    row(4'h4, 3'b111, {3'd1, 4'b0100}, DK, NA, SL, DK);
    // Cabinet housing: drive status, drive fault, fieldbus status, fieldbus fault
    row(4'h1, 3'b111, {3'd0, 4'b0000}, ST, DK, DK, DK);
    row(4'h1, 3'b110, {3'd1, 4'b0000}, SL, DK, SL, DK);
    row(4'h1, 3'b100, {3'd3, 4'b1000}, DK, SL, ST, ST);
    row(4'h1, 3'b000, {3'd3, 4'b0000}, DK, DK, NA, DK);
    row(4'h1, 3'b101, {3'd3, 4'b0000}, DK, DK, ST, DK);
    row(4'h3, 3'b111, {3'd0, 4'b1000}, ST, DK, DK, ST);
    row(4'h3, 3'b111, {3'd1, 4'b0000}, ST, DK, SL, DK);
    row(4'h3, 3'b111, {3'd2, 4'b0000}, ST, DK, SG, DK);
    row(4'h3, 3'b111, {3'd3, 4'b0000}, ST, DK, ST, DK);
    row(4'h3, 3'b111, {3'd4, 4'b0000}, ST, DK, FS, DK);
    row(4'h5, 3'b111, {3'd0, 4'b0000}, ST, DK, DK, ST);
    row(4'h5, 3'b111, {3'd1, 4'b0100}, ST, DK, ST, SL);
    row(4'h5, 3'b111, {3'd3, 4'b0110}, ST, DK, ST, DK);
    row(4'h7, 3'b111, {3'd0, 4'b0000}, ST, DK, DK, DK);
    row(4'h7, 3'b111, {3'd1, 4'b0101}, ST, DK, SL, SL);
    row(4'h7, 3'b111, {3'd3, 4'b0110}, ST, DK, ST, DK);
    row(4'h9, 3'b111, {3'd0, 4'b0000}, ST, DK, DK, ST);
    row(4'h9, 3'b111, {3'd1, 4'b0100}, ST, DK, SL, ST);
    row(4'h9, 3'b111, {3'd2, 4'b0100}, ST, DK, SG, ST);
    row(4'h9, 3'b111, {3'd3, 4'b0100}, ST, DK, ST, DK);
    // Divider registers keep only their low 25 bits
    ahb(1'b1, `REG_SLOW_HALF, 32'hFE000010, `HSIZE_WORD, d);
    rd_chk("slow half written", `REG_SLOW_HALF, 32'h10);
    ahb(1'b1, `REG_FAST_HALF, 32'h00000005, `HSIZE_WORD, d);
    rd_chk("fast half written", `REG_FAST_HALF, 32'h5);
    // Unknown protocol code keeps both fieldbus lamps dark
    row(4'hB, 3'b111, {3'd3, 4'b1110}, ST, DK, DK, DK);
    rd_chk("config", `REG_CONFIG, 32'hB);
    rd_chk("lamps", `REG_LAMPS, 32'h80);
    end_of_test();
  end
endmodule

`default_nettype wire
